// >>> verilog/spc_consts.vh
// Constants for the slave port command interface
`ifndef SPC_CONSTS_VH
`define SPC_CONSTS_VH
`define SPC_ADDR_CMD 2'h0
`define SPC_ADDR_CHAN 2'h1
`define SPC_ADDR_DATA 2'h2
`define SPC_ADDR_STAT 2'h3
`define SPC_INT_CMD 8'h20
`define SPC_INT_CHAN 8'h21
`define SPC_INT_DATA 8'h22
`define SPC_INT_STAT 8'h23
`define SPC_BIT_CMD 0
`define SPC_BIT_CHAN 1
`define SPC_BIT_DATA 2
`define SPC_BIT_RESP 3
`define SPC_BIT_RDATA 4
`define SPC_STAT_RESET 8'h00
`define SPC_BYTE_RESET 8'h00
`endif

// >>> verilog/spc_sync.v
// Two-flop synchroniser for a bundle of asynchronous pin inputs
module spc_sync #(
  parameter WIDTH = 13
) (
  input wire clock,
  input wire reset_n,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          meta_q[i] <= 1'b1;
          sync_out[i] <= 1'b1;
        end else begin
          meta_q[i] <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule

// >>> verilog/spc_regbank.v
// Four-byte register bank with a registered read port
module spc_regbank (
  input wire clock,
  input wire reset_n,
  input wire wr_en,
  input wire [1:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [1:0] rd_addr,
  output reg [7:0] rd_data
);
  reg [7:0] mem_q [0:3];
  integer k;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (k = 0; k < 4; k = k + 1) begin
        mem_q[k] <= 8'h00;
      end
      rd_data <= 8'h00;
    end else begin
      if (wr_en) begin
        mem_q[wr_addr] <= wr_data;
      end
      rd_data <= mem_q[rd_addr];
    end
  end
endmodule

// >>> verilog/spc_slave_port.v
// Slave port: master-facing byte registers and internal-side access
`include "spc_consts.vh"

// How it works
// - Only master command starts an exchange
// - Internal side reads master's three bytes
// - Response write pulls attention low
// - Four byte registers on two address pins
// - Addresses 0-2 split read/write storage
// - Address 0: command in, response out
// - Address 1: channel write, reads as zero
// - Address 2: data in, return data out
// - Status holds per-register update flags
// - Bit 3 set by response, master clears
// - Master status write clears response flag
// - Strobes ignored while select high
// - Address from low and high pins
// - Channel byte selects 256 channels
// - Polling or interrupt chosen by configuration
module spc_slave_port (
  input wire clock,
  input wire reset_n,
  input wire port_select_n,
  input wire port_write_n,
  input wire port_read_n,
  input wire port_addr_lo,
  input wire port_addr_hi,
  input wire [7:0] port_data_in,
  output reg [7:0] port_data_out,
  output reg port_data_oe,
  output reg attention_out_n,
  input wire [7:0] int_addr,
  input wire int_wr,
  input wire int_rd,
  input wire [7:0] int_wdata,
  output reg [7:0] int_rdata,
  input wire irq_enable,
  output reg cmd_irq,
  output reg cmd_event,
  output reg [7:0] cmd_channel
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  wire [12:0] pins_s;
  spc_sync #(.WIDTH(13)) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .async_in({port_data_in, port_addr_hi, port_addr_lo, port_read_n,
               port_write_n, port_select_n}),
    .sync_out(pins_s)
  );
  wire sel_n_s = pins_s[0];
  wire wr_n_s = pins_s[1];
  wire rd_n_s = pins_s[2];
  wire [1:0] addr_s = {pins_s[4], pins_s[3]};
  wire [7:0] data_s = pins_s[12:5];

  // ----------------------------------------------------------------
  // Strobe edge detection
  // ----------------------------------------------------------------
  reg wr_act_q;
  wire wr_act = !sel_n_s && !wr_n_s;
  wire rd_act = !sel_n_s && !rd_n_s;
  // Capture at the leading edge; data must be steady two cycles before
  wire m_wr = wr_act && !wr_act_q;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_act_q <= 1'b0;
    end else begin
      wr_act_q <= wr_act;
    end
  end

  // ----------------------------------------------------------------
  // Master write side: command, channel, outgoing data
  // ----------------------------------------------------------------
  // Master-written bytes live in the bank, kept apart from read-side
  // bytes so a read never returns what the master wrote
  wire bank_wr = m_wr && (addr_s != `SPC_ADDR_STAT);
  wire [7:0] bank_rdata;
  wire int_hit_bank = (int_addr == `SPC_INT_CMD) || (int_addr == `SPC_INT_CHAN) ||
                      (int_addr == `SPC_INT_DATA);
  spc_regbank u_bank (
    .clock(clock),
    .reset_n(reset_n),
    .wr_en(bank_wr),
    .wr_addr(addr_s),
    .wr_data(data_s),
    .rd_addr(int_addr[1:0]),
    .rd_data(bank_rdata)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // One-hot selects; an internal address outside the four bytes
  // selects nothing, so stray accesses leave every register alone
  reg [3:0] m_sel_d;
  always @* begin
    case (addr_s)
      `SPC_ADDR_CMD: m_sel_d = 4'h1;
      `SPC_ADDR_CHAN: m_sel_d = 4'h2;
      `SPC_ADDR_DATA: m_sel_d = 4'h4;
      `SPC_ADDR_STAT: m_sel_d = 4'h8;
      default: m_sel_d = 4'h0;
    endcase
  end

  reg [3:0] int_sel_d;
  always @* begin
    case (int_addr)
      `SPC_INT_CMD: int_sel_d = 4'h1;
      `SPC_INT_CHAN: int_sel_d = 4'h2;
      `SPC_INT_DATA: int_sel_d = 4'h4;
      `SPC_INT_STAT: int_sel_d = 4'h8;
      default: int_sel_d = 4'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // Internal write side: response and return data
  // ----------------------------------------------------------------
  reg [7:0] resp_q;
  reg [7:0] rdata_q;
  reg [7:0] status_q;
  reg [7:0] chan_q;
  wire i_wr_resp = int_wr && int_sel_d[0];
  wire i_wr_data = int_wr && int_sel_d[2];
  wire m_wr_stat = m_wr && m_sel_d[3];
  wire m_wr_cmd = m_wr && m_sel_d[0];
  wire m_wr_chan = m_wr && m_sel_d[1];
  wire m_wr_data = m_wr && m_sel_d[2];
  wire i_rd_cmd = int_rd && int_sel_d[0];
  wire i_rd_chan = int_rd && int_sel_d[1];
  wire i_rd_data = int_rd && int_sel_d[2];

  // ----------------------------------------------------------------
  // Update flags
  // ----------------------------------------------------------------
  // Master bytes are retired by internal reads, results by a master
  // status write; a set in the same cycle as a clear wins so that no
  // event is lost
  wire [4:0] flag_set;
  wire [4:0] flag_clr;
  assign flag_set[`SPC_BIT_CMD] = m_wr_cmd;
  assign flag_set[`SPC_BIT_CHAN] = m_wr_chan;
  assign flag_set[`SPC_BIT_DATA] = m_wr_data;
  assign flag_set[`SPC_BIT_RESP] = i_wr_resp;
  assign flag_set[`SPC_BIT_RDATA] = i_wr_data;
  assign flag_clr[`SPC_BIT_CMD] = i_rd_cmd;
  assign flag_clr[`SPC_BIT_CHAN] = i_rd_chan;
  assign flag_clr[`SPC_BIT_DATA] = i_rd_data;
  assign flag_clr[`SPC_BIT_RESP] = m_wr_stat;
  assign flag_clr[`SPC_BIT_RDATA] = m_wr_stat;

  wire [7:0] status_d;
  genvar f;
  generate
    for (f = 0; f < 8; f = f + 1) begin : g_flag
      if (f <= `SPC_BIT_RDATA) begin : g_used
        assign status_d[f] = flag_set[f] || (status_q[f] && !flag_clr[f]);
      end else begin : g_spare
        assign status_d[f] = 1'b0;
      end
    end
  endgenerate

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= `SPC_STAT_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // ----------------------------------------------------------------
  // Byte registers outside the bank
  // ----------------------------------------------------------------
  // Response byte, read by the master at address 0
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      resp_q <= `SPC_BYTE_RESET;
    end else if (i_wr_resp) begin
      resp_q <= int_wdata;
    end
  end

  // Return data, read by the master at address 2
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= `SPC_BYTE_RESET;
    end else if (i_wr_data) begin
      rdata_q <= int_wdata;
    end
  end

  // Copy of the channel byte so the next command can latch it
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      chan_q <= `SPC_BYTE_RESET;
    end else if (m_wr_chan) begin
      chan_q <= data_s;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  reg [7:0] mrd_d;
  always @* begin
    case (addr_s)
      `SPC_ADDR_CMD: mrd_d = resp_q;
      `SPC_ADDR_CHAN: mrd_d = 8'h00;
      `SPC_ADDR_DATA: mrd_d = rdata_q;
      `SPC_ADDR_STAT: mrd_d = status_q;
      default: mrd_d = 8'h00;
    endcase
  end

  // Pin side: read byte, bus enable and attention
  // Bus enable trails the read strobe by the sync lag plus one flop,
  // so a master must hold its read strobe at least three cycles
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      port_data_out <= 8'h00;
      port_data_oe <= 1'b0;
      attention_out_n <= 1'b1;
    end else begin
      port_data_out <= mrd_d;
      port_data_oe <= rd_act;
      attention_out_n <= !status_d[`SPC_BIT_RESP];
    end
  end

  // Internal side: command pulse, pending interrupt and channel
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cmd_irq <= 1'b0;
      cmd_event <= 1'b0;
      cmd_channel <= 8'h00;
    end else begin
      cmd_event <= m_wr_cmd;
      // Command pending: interrupt if enabled, else poll status bit 0
      cmd_irq <= irq_enable && status_d[`SPC_BIT_CMD];
      if (m_wr_cmd) cmd_channel <= chan_q;
    end
  end

  // ----------------------------------------------------------------
  // Internal read path
  // ----------------------------------------------------------------
  // The bank answers one cycle after the address; a second register
  // keeps int_rdata on a flip-flop at the price of one more cycle,
  // so internal readers take the byte two cycles after the address
  reg int_bank_q;
  reg int_stat_q;
  reg [7:0] int_stat_byte_q;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      int_bank_q <= 1'b0;
      int_stat_q <= 1'b0;
      int_stat_byte_q <= `SPC_STAT_RESET;
    end else begin
      int_bank_q <= int_hit_bank;
      int_stat_q <= int_sel_d[3];
      int_stat_byte_q <= status_q;
    end
  end

  reg [7:0] int_rdata_d;
  always @* begin
    int_rdata_d = 8'h00;
    if (int_bank_q) begin
      int_rdata_d = bank_rdata;
    end else if (int_stat_q) begin
      int_rdata_d = int_stat_byte_q;
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      int_rdata <= 8'h00;
    end else begin
      int_rdata <= int_rdata_d;
    end
  end
endmodule

// >>> testbench/spc_slave_port_chk.sv
// Assertions on the slave port pins and internal strobes
module spc_port_chk (
  input wire clock,
  input wire reset_n,
  input wire port_select_n,
  input wire port_write_n,
  input wire port_read_n,
  input wire port_addr_lo,
  input wire port_addr_hi,
  input wire port_data_oe,
  input wire attention_out_n,
  input wire [7:0] int_addr,
  input wire int_wr,
  input wire irq_enable,
  input wire cmd_irq,
  input wire cmd_event,
  input wire [7:0] cmd_channel
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Properties
  // ----
  default clocking @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  // Three sampled cycles of a status write at the unsynchronised pins
  sequence stat_wr;
    (!port_select_n && !port_write_n && port_addr_lo && port_addr_hi) [*3];
  endsequence
  attn_set_a: assert property (int_wr && int_addr == 8'h20 |=> !attention_out_n)
    else $error("attention not asserted");
  attn_clear_a: assert property (stat_wr |-> ##[1:4] attention_out_n)
    else $error("attention not released");
  attn_cause_a: assert property ($rose(attention_out_n) |->
    $past(port_addr_lo && port_addr_hi && !port_write_n, 2))
    else $error("attention released without status write");
  event_pulse_a: assert property (cmd_event |=> !cmd_event)
    else $error("command event too long");
  event_cause_a: assert property (cmd_event |->
    $past(!port_select_n && !port_write_n && !port_addr_lo && !port_addr_hi, 2))
    else $error("command event without command write");
  select_gate_a: assert property (port_select_n [*5] |-> !cmd_event)
    else $error("strobe taken while deselected");
  oe_cause_a: assert property ($rose(port_data_oe) |->
    $past(!port_select_n && !port_read_n, 2))
    else $error("bus driven without read");
  chan_latch_a: assert property (!$stable(cmd_channel) |-> cmd_event)
    else $error("channel changed outside command");
  irq_mode_a: assert property (!$past(irq_enable) |-> !cmd_irq)
    else $error("interrupt while polling");
endmodule
bind spc_slave_port spc_port_chk chk (.*);

// >>> testbench/spc_master_model.sv
// Model of the external master on the slave port pins
module spc_master_model (
  input wire clock,
  input wire [7:0] port_data_out,
  input wire port_data_oe,
  output logic port_select_n = 1'b1,
  output logic port_write_n = 1'b1,
  output logic port_read_n = 1'b1,
  output logic port_addr_lo = 1'b0,
  output logic port_addr_hi = 1'b0,
  output wire [7:0] port_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wd = 8'h00;
  logic drv = 1'b0;
  // Released bus shows the inverse so stale data never passes
  assign port_data_in = port_data_oe ? port_data_out : drv ? wd : ~wd;
  // ----
  // Bus cycle
  // ----
  // Strobe and gap of five cycles cover the two-cycle sync lag
  task automatic access(input logic sel_n, input logic wr, input logic [1:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(negedge clock);
    {port_addr_hi, port_addr_lo} = a;
    wd = d;
    drv = wr;
    port_select_n = sel_n;
    port_write_n = !wr;
    port_read_n = wr;
    repeat (5) @(negedge clock);
    q = port_data_in;
    port_select_n = 1'b1;
    port_write_n = 1'b1;
    port_read_n = 1'b1;
    drv = 1'b0;
    repeat (5) @(negedge clock);
  endtask
endmodule

// >>> testbench/test_slave_port_command_interface.sv
// Self-checking bench for the slave port
module test_slave_port_command_interface;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] int_addr = 8'h00;
  logic int_wr = 1'b0;
  logic int_rd = 1'b0;
  logic [7:0] int_wdata = 8'h00;
  logic irq_enable = 1'b0;
  wire port_select_n, port_write_n, port_read_n, port_addr_lo, port_addr_hi;
  wire port_data_oe, attention_out_n, cmd_irq, cmd_event;
  wire [7:0] port_data_in, port_data_out, int_rdata, cmd_channel;
  integer seed = 32'h7893;
  integer err_count = 0;
  integer cmp_count = 0;
  integer cycles = 0;
  integer ev_count = 0;
  integer i, k;
  logic [7:0] q;
  logic [63:0] r;
  // Model bytes: command, channel, data, response, return data
  logic [7:0] mb [0:4];
  spc_master_model mst (.*);
  spc_slave_port uut (.*);
  initial forever #2.5 clock = ~clock;
  // ----
  // Checks and accesses
  // ----
  task automatic conclude;
    if (err_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("mismatch at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic iacc(input logic wr, input logic [1:0] a, input logic [7:0] d);
    @(negedge clock);
    int_addr = {6'h08, a};
    int_wr = wr;
    int_rd = !wr;
    int_wdata = d;
    @(negedge clock);
    int_wr = 1'b0;
    int_rd = 1'b0;
    // Read data leaves a second register, two cycles after the address
    @(negedge clock);
  endtask
  always @(posedge clock) begin
    if (cmd_event === 1'b1)
      ev_count = ev_count + 1;
  end
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 4000) begin
      err_count = err_count + 1;
      conclude;
    end
  end
  initial begin
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    check({7'h00, attention_out_n, port_data_oe}, 8'h02);
    for (i = 0; i < 6; i = i + 1) begin
      r = {$random(seed), $random(seed)};
      {mb[0], mb[1], mb[2], mb[3], mb[4]} = r[39:0];
      irq_enable = r[40];
      mst.access(1'b0, 1'b1, 2'h1, mb[1], q);
      mst.access(1'b0, 1'b1, 2'h2, mb[2], q);
      mst.access(1'b0, 1'b1, 2'h0, mb[0], q);
      check(cmd_channel, mb[1]);
      check({7'h00, cmd_irq}, {7'h00, r[40]});
      iacc(1'b0, 2'h3, 8'h00);
      check(int_rdata, 8'h07);
      for (k = 0; k < 3; k = k + 1) begin
        iacc(1'b0, k[1:0], 8'h00);
        check(int_rdata, mb[k]);
      end
      mst.access(1'b1, 1'b1, 2'h0, ~mb[0], q);
      iacc(1'b0, 2'h3, 8'h00);
      check(int_rdata, 8'h00);
      iacc(1'b0, 2'h0, 8'h00);
      check(int_rdata, mb[0]);
      iacc(1'b1, 2'h2, mb[4]);
      iacc(1'b1, 2'h0, mb[3]);
      check({7'h00, attention_out_n}, 8'h00);
      mst.access(1'b0, 1'b0, 2'h3, 8'h00, q);
      check(q & 8'h18, 8'h18);
      mst.access(1'b0, 1'b0, 2'h0, 8'h00, q);
      check(q, mb[3]);
      mst.access(1'b0, 1'b0, 2'h2, 8'h00, q);
      check(q, mb[4]);
      mst.access(1'b0, 1'b0, 2'h1, 8'h00, q);
      check(q, 8'h00);
      mst.access(1'b0, 1'b1, 2'h3, r[47:40], q);
      check({7'h00, attention_out_n}, 8'h01);
    end
    check(ev_count[7:0], 8'h06);
    conclude;
  end
endmodule
